// ---- verilog/imdie_pkg.sv ----
package imdie_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
  localparam logic [7:0] ADDR_EXT_MODE = 8'h10;

  // main mode register field positions
  localparam int MODE_START_BIT = 0;
  localparam int MODE_STOP_BIT = 1;
  localparam int MODE_REPEAT_BIT = 2;
  localparam int MODE_FREE_BIT = 3;
  localparam int MODE_TX_BIT = 4;
  localparam int MODE_MASTER_BIT = 5;
  localparam int MODE_WIDTH = 6;

  // interrupt enable layout, bits above are reserved
  localparam int IRQ_EN_WIDTH = 7;
  localparam int STOP_DETECT_BIT = 5;

  // extended mode register
  localparam int EXT_LEGACY_BIT = 0;

  // reset values
  localparam logic [MODE_WIDTH-1:0] MODE_RESET = 6'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [IRQ_EN_WIDTH-1:0] IRQ_EN_RESET = 7'h00;
  localparam logic LEGACY_RESET = 1'b1;

  // commands handed to the bit engine
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_ADDR = 2'h1;
  localparam logic [1:0] OP_DATA = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_STOP = 3'b100,
    ST_HOLD = 3'b101
  } imdie_state_t;

  // status events, msb first as in the enable register
  typedef struct packed
  {
    logic addressed_slave;
    logic stop_detect;
    logic tx_ready;
    logic rx_ready;
    logic reg_access_ready;
    logic no_ack;
    logic arbitration_loss;
  } imdie_ev_t;

endpackage

// ---- verilog/imdie_top.sv ----
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - no start and no stop gives no activity; stop alone gives only STOP.
// - plain start sends START, address, counted data bytes, no STOP.
// - plain start with stop sends START, address, counted bytes, then STOP.
// - repeat start sends START, address, data until stop or new start.
// - repeat, start and stop all set is reserved and causes no activity.
// - addressed slave ignores transmit select and follows the master's direction.
// - free format slave role is fixed by transmit select for the transfer.
// - master role follows transmit select in both formats.
// - legacy timing bit alters slave transmitter ready timing; reads back, resets one.
// - interrupt enable reserved bits read zero and ignore writes.
// - enable bit 6 gates addressed-as-slave request.
// - enable bit 5 gates stop detected request.
// - enable bit 4 gates transmit ready request.
// - enable bit 3 gates receive ready request.
// - enable bit 2 gates register access ready request.
// - enable bit 1 gates missing acknowledge request.
// - enable bit 0 gates arbitration lost request; all enables reset zero.
// - free format sends no address byte; otherwise addressed format.
module imdie_top
  import imdie_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire imdie_ev_t hw_events,
  input wire logic slave_dir_tx,
  input wire logic cmd_done,
  output logic cmd_valid,
  output logic [1:0] cmd_op,
  output logic tx_role,
  output logic legacy_status_timing,
  output logic irq_req
);

  // reset release through two flops
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // bus pins: two sync stages, plus one history stage on data only for edges
  logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic bus_stop_seen;

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= scl_pin;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_pin;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  // stop on the wire: data rises while clock is high
  assign bus_stop_seen = scl_s2_reg && sda_s2_reg && !sda_s3_reg;

  // wishbone decode; a write lands on the edge that samples ack
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire;
  logic [15:0] wmask;
  logic [15:0] wdata;

  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // control state
  imdie_state_t st_reg, st_next;
  logic [MODE_WIDTH-1:0] mode_reg, mode_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] left_reg, left_next;
  logic [1:0] op_reg, op_next;
  logic role_reg, role_next;
  logic [IRQ_EN_WIDTH-1:0] irq_en_reg, irq_en_next;
  logic legacy_reg, legacy_next;
  logic [IRQ_EN_WIDTH-1:0] pend_reg, pend_next;
  logic irq_reg, irq_next;
  logic tx_ready_dly_reg;
  logic launch_ok;
  logic m_start, m_stop, m_repeat, m_free, m_tx, m_master;
  imdie_ev_t ev_eff;

  assign m_start = mode_reg[MODE_START_BIT];
  assign m_stop = mode_reg[MODE_STOP_BIT];
  assign m_repeat = mode_reg[MODE_REPEAT_BIT];
  assign m_free = mode_reg[MODE_FREE_BIT];
  assign m_tx = mode_reg[MODE_TX_BIT];
  assign m_master = mode_reg[MODE_MASTER_BIT];
  // reserved combination must never launch
  // reserved combo blocked
  assign launch_ok = m_master && !(m_repeat && m_start && m_stop);

  // register read mux and ack timing
  always_comb
  begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    rdata_next = rdata_reg;
    if (ack_next)
    begin
      // unmapped addresses read zero and take no write
      case (wb_adr_i)
        ADDR_MODE: rdata_next = {26'h0000000, mode_reg};
        ADDR_COUNT: rdata_next = {16'h0000, count_reg};
        ADDR_STATUS: rdata_next = {25'h0000000, pend_reg};
        ADDR_IRQ_EN: rdata_next = {25'h0000000, irq_en_reg};
        ADDR_EXT_MODE: rdata_next = {31'h00000000, legacy_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // transfer sequencer, mode bits and count
  always_comb
  begin
    st_next = st_reg;
    mode_next = mode_reg;
    count_next = count_reg;
    left_next = left_reg;
    if (wr_fire && wb_adr_i == ADDR_MODE)
    begin
      mode_next = (mode_reg & ~wmask[MODE_WIDTH-1:0]) | (wdata[MODE_WIDTH-1:0] &
        wmask[MODE_WIDTH-1:0]);
    end
    if (wr_fire && wb_adr_i == ADDR_COUNT)
    begin
      count_next = (count_reg & ~wmask) | (wdata & wmask);
    end
    case (st_reg)
      ST_IDLE, ST_HOLD:
      begin
        if (launch_ok && m_start)
        begin
          st_next = ST_START;
          mode_next[MODE_START_BIT] = 1'b0;
          left_next = count_reg;
        end
        else if (launch_ok && m_stop)
        begin
          st_next = ST_STOP;
        end
      end
      ST_START:
      begin
        if (cmd_done)
        begin
          if (!m_free)
            st_next = ST_ADDR;
          else if (m_repeat || left_reg != 16'h0000)
            st_next = ST_DATA;
          else
            st_next = m_stop ? ST_STOP : ST_HOLD;
        end
      end
      ST_ADDR:
      begin
        if (cmd_done)
        begin
          if (m_repeat || left_reg != 16'h0000)
            st_next = ST_DATA;
          else
            st_next = m_stop ? ST_STOP : ST_HOLD;
        end
      end
      ST_DATA:
      begin
        if (cmd_done)
        begin
          left_next = left_reg - 16'h0001;
          if (m_repeat)
          begin
            if (m_stop)
              st_next = ST_STOP;
            else if (m_start)
            begin
              st_next = ST_START;
              mode_next[MODE_START_BIT] = 1'b0;
            end
          end
          else if (left_reg == 16'h0001)
          begin
            st_next = m_stop ? ST_STOP : ST_HOLD;
          end
        end
      end
      ST_STOP:
      begin
        if (cmd_done)
        begin
          st_next = ST_IDLE;
          mode_next[MODE_STOP_BIT] = 1'b0;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // software write in the same cycle wins over hardware clearing
    if (wr_fire && wb_adr_i == ADDR_MODE && wmask[0])
    begin
      mode_next[MODE_START_BIT] = wdata[MODE_START_BIT];
      mode_next[MODE_STOP_BIT] = wdata[MODE_STOP_BIT];
    end
    case (st_next)
      ST_START: op_next = OP_START;
      ST_ADDR: op_next = OP_ADDR;
      ST_DATA: op_next = OP_DATA;
      ST_STOP: op_next = OP_STOP;
      default: op_next = op_reg;
    endcase
    if (m_master || m_free)
      role_next = m_tx;
    else
      role_next = slave_dir_tx;
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_reg <= ST_IDLE;
      mode_reg <= MODE_RESET;
      count_reg <= COUNT_RESET;
      left_reg <= COUNT_RESET;
      op_reg <= OP_START;
      role_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      count_reg <= count_next;
      left_reg <= left_next;
      op_reg <= op_next;
      role_reg <= role_next;
    end
  end

  assign cmd_valid = (st_reg == ST_START) || (st_reg == ST_ADDR) ||
    (st_reg == ST_DATA) || (st_reg == ST_STOP);
  assign cmd_op = op_reg;
  assign tx_role = role_reg;
  assign legacy_status_timing = legacy_reg;

  // enables, legacy bit and pending events
  always_comb
  begin
    irq_en_next = irq_en_reg;
    legacy_next = legacy_reg;
    ev_eff = hw_events;
    ev_eff.stop_detect = hw_events.stop_detect || bus_stop_seen;
    if (!legacy_reg && !m_master && role_reg)
      ev_eff.tx_ready = tx_ready_dly_reg;
    if (wr_fire && wb_adr_i == ADDR_IRQ_EN && wmask[0])
      irq_en_next = wdata[IRQ_EN_WIDTH-1:0];
    // upper bits ignored, software keeps them zero
    if (wr_fire && wb_adr_i == ADDR_EXT_MODE && wmask[0])
      legacy_next = wdata[EXT_LEGACY_BIT];
    // write one clears, a new event in the same cycle wins
    pend_next = pend_reg;
    if (wr_fire && wb_adr_i == ADDR_STATUS && wmask[0])
      pend_next = pend_reg & ~wdata[IRQ_EN_WIDTH-1:0];
    pend_next = pend_next | ev_eff;
    irq_next = |(pend_reg & irq_en_reg);
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      irq_en_reg <= IRQ_EN_RESET;
      legacy_reg <= LEGACY_RESET;
      pend_reg <= IRQ_EN_RESET;
      irq_reg <= 1'b0;
      tx_ready_dly_reg <= 1'b0;
    end
    else
    begin
      irq_en_reg <= irq_en_next;
      legacy_reg <= legacy_next;
      pend_reg <= pend_next;
      irq_reg <= irq_next;
      tx_ready_dly_reg <= hw_events.tx_ready;
    end
  end

  assign irq_req = irq_reg;

  // checks
  sequence s_byte_done;
    st_reg == ST_DATA && cmd_done;
  endsequence

  sequence s_idle_ready;
    (st_reg == ST_IDLE || st_reg == ST_HOLD) && m_master && !wr_fire;
  endsequence

  property p_reserved_quiet;
    @(posedge clock) disable iff (!rst_sync_n)
    s_idle_ready ##0 (m_repeat && m_start && m_stop) |=> !cmd_valid;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet)
    else $error("reserved combination launched bus activity");

  property p_stop_only;
    @(posedge clock) disable iff (!rst_sync_n)
    s_idle_ready ##0 (!m_start && m_stop) |=> st_reg == ST_STOP && cmd_op == OP_STOP;
  endproperty
  a_stop_only: assert property (p_stop_only)
    else $error("stop request did not issue stop");

  property p_start_launch;
    @(posedge clock) disable iff (!rst_sync_n)
    s_idle_ready ##0 (m_start && !(m_repeat && m_stop)) |=> cmd_op == OP_START && cmd_valid;
  endproperty
  a_start_launch: assert property (p_start_launch)
    else $error("start request did not issue start");

  property p_count_end_hold;
    @(posedge clock) disable iff (!rst_sync_n)
    s_byte_done ##0 (!m_repeat && !m_stop && left_reg == 16'h0001) |=> st_reg == ST_HOLD;
  endproperty
  a_count_end_hold: assert property (p_count_end_hold)
    else $error("counted transfer did not end without stop");

  property p_count_end_stop;
    @(posedge clock) disable iff (!rst_sync_n)
    s_byte_done ##0 (!m_repeat && m_stop && left_reg == 16'h0001) |=> cmd_op == OP_STOP;
  endproperty
  a_count_end_stop: assert property (p_count_end_stop)
    else $error("counted transfer did not end with stop");

  property p_repeat_go_on;
    @(posedge clock) disable iff (!rst_sync_n)
    s_byte_done ##0 (m_repeat && !m_stop && !m_start) |=> st_reg == ST_DATA;
  endproperty
  a_repeat_go_on: assert property (p_repeat_go_on)
    else $error("repeat mode stopped sending data");

  property p_master_role;
    @(posedge clock) disable iff (!rst_sync_n)
    m_master |=> tx_role == $past(m_tx);
  endproperty
  a_master_role: assert property (p_master_role)
    else $error("master role does not follow transmit select");

  property p_slave_role;
    @(posedge clock) disable iff (!rst_sync_n)
    (!m_master && !m_free) |=> tx_role == $past(slave_dir_tx);
  endproperty
  a_slave_role: assert property (p_slave_role)
    else $error("addressed slave role does not follow master");

  property p_irq_gate;
    @(posedge clock) disable iff (!rst_sync_n)
    ##1 irq_req == |($past(pend_reg) & $past(irq_en_reg));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request does not match enabled pending events");

  property p_ier_reserved;
    @(posedge clock) disable iff (!rst_sync_n)
    ack_reg && !wb_we_i && $past(wb_adr_i) == ADDR_IRQ_EN |-> wb_dat_o[31:7] == 25'h0000000;
  endproperty
  a_ier_reserved: assert property (p_ier_reserved)
    else $error("enable register reserved bits read nonzero");

endmodule

// ---- verification/imdie_engine_model.sv ----
`timescale 1ns/10ps
// stand-in for the bit engine and the far devices on the wire
module imdie_engine_model
  import imdie_pkg::*;
(
  input wire logic clock,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [3:0] lag,
  output logic cmd_done,
  output logic scl,
  output logic sda
);
  logic [1:0] op;
  // one command at a time; wire pulled high, scl still outside frames
  initial
  begin
    cmd_done = 1'b0;
    scl = 1'b1;
    sda = 1'b1;
    forever
    begin
      @(posedge clock);
      if (cmd_valid === 1'b1)
      begin
        op = cmd_op;
        repeat (lag) @(posedge clock);
        // sda moves only while scl is low, except start and stop
        // wire moves on clock edges by nonblocking update, 160 ns per bit
        scl <= 1'b0;
        repeat (2) @(posedge clock);
        sda <= (op == OP_START) ? 1'b1 : (op == OP_STOP) ? 1'b0 : ~sda;
        repeat (2) @(posedge clock);
        scl <= 1'b1;
        repeat (2) @(posedge clock);
        if (op == OP_START || op == OP_STOP)
          sda <= ~sda;
        repeat (2) @(posedge clock);
        cmd_done <= 1'b1;
        @(posedge clock) cmd_done <= 1'b0;
        // next command shows one cycle after done
        @(posedge clock);
      end
    end
  end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
  import imdie_pkg::*;
;
  logic clock, rst_n, cyc, stb, we, ack, scl, sda, sdir, done;
  logic cvalid, role, legacy, irq;
  logic [7:0] adr;
  logic [3:0] sel, lag;
  logic [31:0] wdat, rdat, q, rng, en;
  logic [1:0] cop;
  logic [15:0] seq;
  logic [23:0] e;
  imdie_ev_t ev;
  int fails, checks, cycles, n, i, c, t;
  logic [5:0] modes [8] = '{6'h20, 6'h22, 6'h26, 6'h24, 6'h21, 6'h23, 6'h27, 6'h2b};

  imdie_top dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .scl_pin(scl), .sda_pin(sda),
    .hw_events(ev), .slave_dir_tx(sdir), .cmd_done(done), .cmd_valid(cvalid),
    .cmd_op(cop), .tx_role(role), .legacy_status_timing(legacy), .irq_req(irq));

  imdie_engine_model eng (.clock(clock), .cmd_valid(cvalid), .cmd_op(cop),
    .lag(lag), .cmd_done(done), .scl(scl), .sda(sda));

  // free running clock, 20 ns
  always #10 clock = ~clock;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // commands expected from mode bits and byte count; reserved mix gives none
  function automatic logic [23:0] expect_ops(logic [5:0] m, int cnt);
    logic [15:0] s;
    int k;
    s = '0;
    k = 0;
    if (m[MODE_MASTER_BIT] && m[MODE_START_BIT] && !m[MODE_REPEAT_BIT])
    begin
      s = {s[13:0], OP_START};
      k++;
      if (!m[MODE_FREE_BIT])
      begin
        s = {s[13:0], OP_ADDR};
        k++;
      end
      repeat (cnt)
      begin
        s = {s[13:0], OP_DATA};
        k++;
      end
    end
    if (m[MODE_MASTER_BIT] && m[MODE_STOP_BIT] && !(m[MODE_REPEAT_BIT] && m[MODE_START_BIT]))
    begin
      s = {s[13:0], OP_STOP};
      k++;
    end
    return {8'(k), s};
  endfunction

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  // single classic cycle; held until ack is sampled, read data taken there
  // no local limit: only the global cycle ceiling ends a hung access
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h3;
    do
    begin
      @(posedge clock);
    end
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // logs each command the engine completes; hang limit
  always @(posedge clock)
  begin
    cycles++;
    if (cvalid === 1'b1 && done === 1'b1)
    begin
      seq = {seq[13:0], cop};
      n++;
    end
    if (cycles == 20000)
    begin
      fails++;
      stop_test();
    end
  end

  initial
  begin
    {clock, rst_n, cyc, stb, we, sdir} = '0;
    {adr, sel, wdat, ev, lag} = '0;
    rng = 32'ha8c3729d;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    tick(4);
    // reset values, access kinds, unmapped place
    chk(legacy, 1);
    wb(ADDR_IRQ_EN, 0, 0);
    chk(q, 0);
    wb(ADDR_EXT_MODE, 0, 0);
    chk(q, 1);
    wb(ADDR_EXT_MODE, 1, 0);
    wb(ADDR_EXT_MODE, 0, 0);
    chk(q, 0);
    chk(legacy, 0);
    wb(ADDR_EXT_MODE, 1, 1);
    wb(ADDR_IRQ_EN, 1, 32'hffff);
    wb(ADDR_IRQ_EN, 0, 0);
    chk(q, 32'h7f);
    wb(8'h40, 1, 32'h5a);
    wb(8'h40, 0, 0);
    chk(q, 0);
    // each source against a random enable set, then mask and clear
    // no fifo mode here
    wb(ADDR_STATUS, 1, 32'h7f);
    for (i = 0; i < 7; i++)
    begin
      en = xs() & 32'h7f;
      wb(ADDR_IRQ_EN, 1, en);
      ev <= imdie_ev_t'(7'h1 << i);
      @(posedge clock);
      ev <= '0;
      tick(3);
      chk(irq, en[i]);
      wb(ADDR_STATUS, 0, 0);
      chk(q, 32'h1 << i);
      wb(ADDR_IRQ_EN, 1, 32'h1 << i);
      tick(2);
      chk(irq, 1);
      wb(ADDR_IRQ_EN, 1, 0);
      tick(2);
      chk(irq, 0);
      wb(ADDR_STATUS, 1, 32'h1 << i);
      wb(ADDR_IRQ_EN, 1, 32'h7f);
      tick(2);
      chk(irq, 0);
    end
    // command decode; stop on the wire must raise the stop request
    wb(ADDR_IRQ_EN, 1, 32'h1 << STOP_DETECT_BIT);
    for (i = 0; i < 8; i++)
    begin
      c = 1 + xs() % 3;
      lag <= 4'(xs());
      wb(ADDR_COUNT, 1, c);
      seq = '0;
      n = 0;
      wb(ADDR_MODE, 1, 32'(modes[i]));
      e = expect_ops(modes[i], c);
      for (t = 0; n < e[23:16] && t < 3000; t++)
        @(posedge clock);
      tick(60);
      chk(n, e[23:16]);
      chk(seq, e[15:0]);
      chk(irq, e[23:16] != 0 && e[1:0] == OP_STOP);
      wb(ADDR_STATUS, 1, 32'h7f);
    end
    // repeat mode runs past the count until stop is asked for
    seq = '0;
    n = 0;
    wb(ADDR_COUNT, 1, 1);
    wb(ADDR_MODE, 1, 32'h25);
    for (t = 0; n < 6 && t < 3000; t++)
      @(posedge clock);
    wb(ADDR_MODE, 1, 32'h26);
    for (t = 0; seq[1:0] != OP_STOP && t < 3000; t++)
      @(posedge clock);
    tick(60);
    chk(n >= 7, 1);
    chk(seq[1:0], OP_STOP);
    chk(cvalid, 0);
    // role from master, free format, transmit select and slave direction
    for (i = 0; i < 16; i++)
    begin
      sdir <= i[0];
      wb(ADDR_MODE, 1, {26'h0, i[3], i[2], i[1], 3'h0});
      tick(3);
      chk(role, (i[3] | i[1]) ? i[2] : i[0]);
    end
    // slave transmitter: a clear legacy bit holds the ready event back a cycle
    for (i = 0; i < 2; i++)
    begin
      sdir <= 1'b1;
      wb(ADDR_MODE, 1, 0);
      wb(ADDR_EXT_MODE, 1, i);
      wb(ADDR_STATUS, 1, 32'h7f);
      wb(ADDR_IRQ_EN, 1, 32'h10);
      ev <= imdie_ev_t'(7'h10);
      @(posedge clock);
      ev <= '0;
      tick(2);
      chk(irq, i);
      tick(1);
      chk(irq, 1);
    end
    stop_test();
  end
endmodule
